// file: include/gpm_pkg.sv
`default_nettype none

package gpm_pkg;

	// Register indices; byte address on the bus is four times the index
	localparam logic [15:0] IDX_CTRL     = 16'hc006;
	localparam logic [15:0] IDX_OUT_LO   = 16'hc01e;
	localparam logic [15:0] IDX_IN_LO    = 16'hc020;
	localparam logic [15:0] IDX_DIR_LO   = 16'hc022;
	localparam logic [15:0] IDX_OUT_HI   = 16'hc024;
	localparam logic [15:0] IDX_IN_HI    = 16'hc026;
	localparam logic [15:0] IDX_DIR_HI   = 16'hc028;
	localparam logic [15:0] IDX_INT_STAT = 16'hc030;
	localparam logic [15:0] IDX_INT_MASK = 16'hc032;

	// Pin-function control register fields
	localparam int CTRL_WP_BIT    = 15;
	localparam int CTRL_TXEN_BIT  = 14;
	localparam int CTRL_ALTSS_BIT = 11;
	localparam int CTRL_MODE_MSB  = 10;
	localparam int CTRL_MODE_LSB  = 8;
	localparam int CTRL_FSP_BIT   = 7;
	localparam int CTRL_SPI_BIT   = 5;
	localparam int CTRL_POL_BIT   = 1;
	localparam int CTRL_INTEN_BIT = 0;
	localparam logic [15:0] CTRL_WR_MASK = 16'hcfa3;

	// Pin-function codes
	localparam logic [2:0] MODE_GPIO = 3'h0;
	localparam logic [2:0] MODE_HOST = 3'h5;
	localparam logic [2:0] MODE_SCAN = 3'h6;

	// Pin placement
	localparam logic [15:0] HI_PIN_MASK  = 16'he1f8;
	localparam int          FSP_LSB      = 12;
	localparam int          SPI_LSB      = 8;
	localparam int          SPI_SS_SLOT  = 1;
	localparam int          PIN_SS_ALT   = 15;
	localparam int          PIN_TXEN     = 30;
	localparam int          PIN_IRQ      = 24;
	localparam int          HOST_LO_PINS = 16;
	localparam int          HOST_HI_SKIP = 3;

	// Reset values
	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam logic [31:0] RST_PINS      = 32'h0000_0000;
	localparam logic [31:0] PINS_RELEASED = 32'hffff_ffff;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		GPM_WR_IDLE = 2'h1,
		GPM_WR_RESP = 2'h2
	} gpm_wr_state_e;

	typedef enum logic [1:0] {
		GPM_RD_IDLE = 2'h1,
		GPM_RD_DATA = 2'h2
	} gpm_rd_state_e;

endpackage

`default_nettype wire

// file: include/gpm_irq_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries the pin interrupt controls and the sticky status between units
interface gpm_irq_if;
	logic level;
	logic rise_sel;
	logic local_en;
	logic global_en;
	logic mask;
	logic clr;
	logic status;
	logic irq;

	modport ctrl (
		output level, rise_sel, local_en, global_en, mask, clr,
		input  status, irq
	);
	modport unit (
		input  level, rise_sel, local_en, global_en, mask, clr,
		output status, irq
	);
endinterface

`default_nettype wire

// file: hdl/gpm_edge_irq.sv
`timescale 1ns/10ps
`default_nettype none

module gpm_edge_irq (
	input wire logic   clk_i,
	input wire logic   reset_i,
	gpm_irq_if.unit    irq_bus
);
	logic seen_reg;
	logic seen_next;
	logic prev_reg;
	logic prev_next;
	logic stat_reg;
	logic stat_next;
	logic irq_reg;
	logic irq_next;
	logic edge_hit;

	// Edge detect; the first sample after reset only seeds the history
	always_comb begin
		seen_next = 1'b1;
		prev_next = irq_bus.level;
		edge_hit  = 1'b0;
		if (seen_reg && irq_bus.local_en) begin
			if (irq_bus.rise_sel) begin
				edge_hit = irq_bus.level & ~prev_reg;
			end else begin
				edge_hit = ~irq_bus.level & prev_reg;
			end
		end
		// Set wins over a clear in the same cycle
		stat_next = edge_hit | (stat_reg & ~irq_bus.clr);
		irq_next  = stat_next & irq_bus.mask & irq_bus.global_en;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			seen_reg <= 1'b0;
			prev_reg <= 1'b0;
			stat_reg <= 1'b0;
			irq_reg  <= 1'b0;
		end else begin
			seen_reg <= seen_next;
			prev_reg <= prev_next;
			stat_reg <= stat_next;
			irq_reg  <= irq_next;
		end
	end

	assign irq_bus.status = stat_reg;
	assign irq_bus.irq    = irq_reg;
endmodule

`default_nettype wire

// file: hdl/gpm_port.sv
// Functional notes
// - Function field picks plain I/O or host port
// - Fast serial bit routes pins 15..12
// - SPI bit routes pins 11..8
// - Alternate select moves slave select to 15
// - Polarity bit picks rising or falling edge
// - Interrupt needs local and global enables
// - Output register reads back last written value
// - Output bit drives pin level when output
// - Output words cover low and listed high pins
// - Input words return present pin levels
// - Direction one means output, zero input
// - Write protect locks function field until reset
// - Alternate select moves select from 9 to 15
// - Export bit drives transmit enable on pin 30
`timescale 1ns/10ps
`default_nettype none

module gpm_port #(
	parameter int ADDR_W = 18,
	parameter int HOST_W = 22
) (
	input  wire logic              CLK_SYS_I,
	input  wire logic              RESET_I,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input  wire logic              S_AXI_AWVALID_I,
	output logic                   S_AXI_AWREADY_O,
	input  wire logic [31:0]       S_AXI_WDATA_I,
	input  wire logic [3:0]        S_AXI_WSTRB_I,
	input  wire logic              S_AXI_WVALID_I,
	output logic                   S_AXI_WREADY_O,
	output logic [1:0]             S_AXI_BRESP_O,
	output logic                   S_AXI_BVALID_O,
	input  wire logic              S_AXI_BREADY_I,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input  wire logic              S_AXI_ARVALID_I,
	output logic                   S_AXI_ARREADY_O,
	output logic [31:0]            S_AXI_RDATA_O,
	output logic [1:0]             S_AXI_RRESP_O,
	output logic                   S_AXI_RVALID_O,
	input  wire logic              S_AXI_RREADY_I,
	input  wire logic [31:0]       GPIO_I,
	output logic [31:0]            GPIO_O,
	output logic [31:0]            GPIO_OE_N_O,
	input  wire logic [3:0]        FAST_SERIAL_DOUT_I,
	input  wire logic [3:0]        FAST_SERIAL_DRIVE_I,
	output logic [3:0]             FAST_SERIAL_DIN_O,
	input  wire logic [3:0]        SPI_DOUT_I,
	input  wire logic [3:0]        SPI_DRIVE_I,
	output logic [3:0]             SPI_DIN_O,
	output logic                   SLAVE_SELECT_INPUT_O,
	input  wire logic [HOST_W-1:0] HOST_PORT_DOUT_I,
	input  wire logic [HOST_W-1:0] HOST_PORT_DRIVE_I,
	output logic [HOST_W-1:0]      HOST_PORT_DIN_O,
	input  wire logic              TX_ENABLE_STATE_I,
	input  wire logic              PIN_INT_GLOBAL_EN_I,
	output logic                   FAST_SERIAL_ROUTED_O,
	output logic                   SPI_ROUTED_O,
	output logic                   HOST_PORT_ROUTED_O,
	output logic                   SCAN_MODE_O,
	output logic                   IRQ_O
);
	gpm_pkg::gpm_wr_state_e wr_state_reg;
	gpm_pkg::gpm_wr_state_e wr_state_next;
	gpm_pkg::gpm_rd_state_e rd_state_reg;
	gpm_pkg::gpm_rd_state_e rd_state_next;
	logic        aw_got_reg, aw_got_next;
	logic        w_got_reg, w_got_next;
	logic [15:0] wr_idx_reg, wr_idx_next;
	logic [15:0] wr_data_reg, wr_data_next;
	logic [1:0]  wr_strb_reg, wr_strb_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [15:0] ctrl_reg, ctrl_next;
	logic [15:0] out_lo_reg, out_lo_next;
	logic [15:0] out_hi_reg, out_hi_next;
	logic [15:0] dir_lo_reg, dir_lo_next;
	logic [15:0] dir_hi_reg, dir_hi_next;
	logic        mask_reg, mask_next;
	logic        int_clr;
	logic        wr_fire;
	logic [15:0] rd_idx;
	logic [31:0] pin_in_reg;
	logic [31:0] pin_o_reg, pin_o_next;
	logic [31:0] oe_n_reg, oe_n_next;
	logic        ss_reg, ss_next;
	logic [2:0]  mode;
	logic        host_on, fsp_on, spi_on, alt_on;

	gpm_irq_if irq_bus ();

	// Index of a register as seen from a byte address
	function automatic logic [15:0] to_idx(input logic [ADDR_W-1:0] a);
		to_idx = a[17:2];
	endfunction

	// Both bus directions share one view of what is mapped
	function automatic logic is_mapped(input logic [15:0] idx);
		case (idx)
			gpm_pkg::IDX_CTRL, gpm_pkg::IDX_OUT_LO, gpm_pkg::IDX_IN_LO,
			gpm_pkg::IDX_DIR_LO, gpm_pkg::IDX_OUT_HI, gpm_pkg::IDX_IN_HI,
			gpm_pkg::IDX_DIR_HI, gpm_pkg::IDX_INT_STAT,
			gpm_pkg::IDX_INT_MASK: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] strb);
		merge16 = old;
		if (strb[0]) begin
			merge16[7:0] = nw[7:0];
		end
		if (strb[1]) begin
			merge16[15:8] = nw[15:8];
		end
	endfunction

	// Host port slot to pin number: slots 0..15 then pins 19..24
	function automatic int host_pin(input int k);
		host_pin = (k < gpm_pkg::HOST_LO_PINS) ? k :
			k + gpm_pkg::HOST_HI_SKIP;
	endfunction

	assign mode    = ctrl_reg[gpm_pkg::CTRL_MODE_MSB:gpm_pkg::CTRL_MODE_LSB];
	assign host_on = (mode == gpm_pkg::MODE_HOST);
	assign fsp_on  = ctrl_reg[gpm_pkg::CTRL_FSP_BIT] & ~host_on;
	assign spi_on  = ctrl_reg[gpm_pkg::CTRL_SPI_BIT] & ~host_on;
	assign alt_on  = ctrl_reg[gpm_pkg::CTRL_ALTSS_BIT] & spi_on;
	assign wr_fire = (wr_state_reg == gpm_pkg::GPM_WR_IDLE) &
		aw_got_reg & w_got_reg;
	assign rd_idx  = to_idx(S_AXI_ARADDR_I);

	// Write channel, register updates and write-one-to-clear
	always_comb begin
		wr_state_next = wr_state_reg;
		aw_got_next   = aw_got_reg;
		w_got_next    = w_got_reg;
		wr_idx_next   = wr_idx_reg;
		wr_data_next  = wr_data_reg;
		wr_strb_next  = wr_strb_reg;
		bresp_next    = bresp_reg;
		ctrl_next     = ctrl_reg;
		out_lo_next   = out_lo_reg;
		out_hi_next   = out_hi_reg;
		dir_lo_next   = dir_lo_reg;
		dir_hi_next   = dir_hi_reg;
		mask_next     = mask_reg;
		int_clr       = 1'b0;
		case (wr_state_reg)
			gpm_pkg::GPM_WR_IDLE: begin
				// Address and data are taken in either order
				if (S_AXI_AWVALID_I && !aw_got_reg) begin
					aw_got_next = 1'b1;
					wr_idx_next = to_idx(S_AXI_AWADDR_I);
				end
				if (S_AXI_WVALID_I && !w_got_reg) begin
					w_got_next   = 1'b1;
					wr_data_next = S_AXI_WDATA_I[15:0];
					wr_strb_next = S_AXI_WSTRB_I[1:0];
				end
				if (wr_fire) begin
					aw_got_next   = 1'b0;
					w_got_next    = 1'b0;
					wr_state_next = gpm_pkg::GPM_WR_RESP;
					bresp_next    = is_mapped(wr_idx_reg) ?
						gpm_pkg::RESP_OKAY : gpm_pkg::RESP_SLVERR;
					case (wr_idx_reg)
						gpm_pkg::IDX_CTRL: begin
							ctrl_next = merge16(ctrl_reg, wr_data_reg,
								wr_strb_reg) & gpm_pkg::CTRL_WR_MASK;
							if (ctrl_reg[gpm_pkg::CTRL_WP_BIT]) begin
								ctrl_next[gpm_pkg::CTRL_MODE_MSB:
									gpm_pkg::CTRL_MODE_LSB] = mode;
								ctrl_next[gpm_pkg::CTRL_WP_BIT] = 1'b1;
							end
						end
						gpm_pkg::IDX_OUT_LO: out_lo_next =
							merge16(out_lo_reg, wr_data_reg, wr_strb_reg);
						gpm_pkg::IDX_OUT_HI: out_hi_next =
							merge16(out_hi_reg, wr_data_reg, wr_strb_reg)
							& gpm_pkg::HI_PIN_MASK;
						gpm_pkg::IDX_DIR_LO: dir_lo_next =
							merge16(dir_lo_reg, wr_data_reg, wr_strb_reg);
						gpm_pkg::IDX_DIR_HI: dir_hi_next =
							merge16(dir_hi_reg, wr_data_reg, wr_strb_reg)
							& gpm_pkg::HI_PIN_MASK;
						gpm_pkg::IDX_INT_STAT:
							int_clr = wr_strb_reg[0] & wr_data_reg[0];
						gpm_pkg::IDX_INT_MASK: if (wr_strb_reg[0]) begin
							mask_next = wr_data_reg[0];
						end
						default: ;
					endcase
				end
			end
			gpm_pkg::GPM_WR_RESP: begin
				if (S_AXI_BREADY_I) begin
					wr_state_next = gpm_pkg::GPM_WR_IDLE;
				end
			end
			default: wr_state_next = gpm_pkg::GPM_WR_IDLE;
		endcase
	end

	// Read channel; output words return what was written, not the pins
	always_comb begin
		rd_state_next = rd_state_reg;
		rdata_next    = rdata_reg;
		rresp_next    = rresp_reg;
		case (rd_state_reg)
			gpm_pkg::GPM_RD_IDLE: begin
				if (S_AXI_ARVALID_I) begin
					rd_state_next = gpm_pkg::GPM_RD_DATA;
					rresp_next    = is_mapped(rd_idx) ?
						gpm_pkg::RESP_OKAY : gpm_pkg::RESP_SLVERR;
					rdata_next    = 32'h0000_0000;
					case (rd_idx)
						gpm_pkg::IDX_CTRL:   rdata_next[15:0] = ctrl_reg;
						gpm_pkg::IDX_OUT_LO: rdata_next[15:0] = out_lo_reg;
						gpm_pkg::IDX_OUT_HI: rdata_next[15:0] = out_hi_reg;
						gpm_pkg::IDX_IN_LO:  rdata_next[15:0] =
							pin_in_reg[15:0];
						gpm_pkg::IDX_IN_HI:  rdata_next[15:0] =
							pin_in_reg[31:16] & gpm_pkg::HI_PIN_MASK;
						gpm_pkg::IDX_DIR_LO: rdata_next[15:0] = dir_lo_reg;
						gpm_pkg::IDX_DIR_HI: rdata_next[15:0] = dir_hi_reg;
						gpm_pkg::IDX_INT_STAT: rdata_next[0] = irq_bus.status;
						gpm_pkg::IDX_INT_MASK: rdata_next[0] = mask_reg;
						default: ;
					endcase
				end
			end
			gpm_pkg::GPM_RD_DATA: begin
				if (S_AXI_RREADY_I) begin
					rd_state_next = gpm_pkg::GPM_RD_IDLE;
				end
			end
			default: rd_state_next = gpm_pkg::GPM_RD_IDLE;
		endcase
	end

	// Pin ownership; later assignments take precedence over earlier ones
	always_comb begin
		logic [31:0] drv;
		drv        = {dir_hi_reg, dir_lo_reg};
		pin_o_next = {out_hi_reg, out_lo_reg};
		if (host_on) begin
			for (int k = 0; k < HOST_W; k++) begin
				pin_o_next[host_pin(k)] = HOST_PORT_DOUT_I[k];
				drv[host_pin(k)]        = HOST_PORT_DRIVE_I[k];
			end
		end
		if (fsp_on) begin
			for (int k = 0; k < 4; k++) begin
				pin_o_next[gpm_pkg::FSP_LSB+k] = FAST_SERIAL_DOUT_I[k];
				drv[gpm_pkg::FSP_LSB+k]        = FAST_SERIAL_DRIVE_I[k];
			end
		end
		if (spi_on) begin
			for (int k = 0; k < 4; k++) begin
				pin_o_next[gpm_pkg::SPI_LSB+k] = SPI_DOUT_I[k];
				drv[gpm_pkg::SPI_LSB+k]        = SPI_DRIVE_I[k];
			end
		end
		if (alt_on) begin
			// Default select pin goes back to plain I/O, pin 15 listens
			pin_o_next[gpm_pkg::SPI_LSB+gpm_pkg::SPI_SS_SLOT] =
				out_lo_reg[gpm_pkg::SPI_LSB+gpm_pkg::SPI_SS_SLOT];
			drv[gpm_pkg::SPI_LSB+gpm_pkg::SPI_SS_SLOT] =
				dir_lo_reg[gpm_pkg::SPI_LSB+gpm_pkg::SPI_SS_SLOT];
			drv[gpm_pkg::PIN_SS_ALT] = 1'b0;
		end
		if (ctrl_reg[gpm_pkg::CTRL_TXEN_BIT]) begin
			pin_o_next[gpm_pkg::PIN_TXEN] = TX_ENABLE_STATE_I;
			drv[gpm_pkg::PIN_TXEN]        = 1'b1;
		end
		// Pins that do not exist never drive
		oe_n_next = ~(drv & {gpm_pkg::HI_PIN_MASK, 16'hffff});
		ss_next   = alt_on ? pin_in_reg[gpm_pkg::PIN_SS_ALT] :
			pin_in_reg[gpm_pkg::SPI_LSB+gpm_pkg::SPI_SS_SLOT];
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			wr_state_reg <= gpm_pkg::GPM_WR_IDLE;
			rd_state_reg <= gpm_pkg::GPM_RD_IDLE;
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			wr_idx_reg   <= gpm_pkg::RST_WORD;
			wr_data_reg  <= gpm_pkg::RST_WORD;
			wr_strb_reg  <= 2'h0;
			bresp_reg    <= gpm_pkg::RESP_OKAY;
			rdata_reg    <= gpm_pkg::RST_PINS;
			rresp_reg    <= gpm_pkg::RESP_OKAY;
			ctrl_reg     <= gpm_pkg::RST_WORD;
			out_lo_reg   <= gpm_pkg::RST_WORD;
			out_hi_reg   <= gpm_pkg::RST_WORD;
			dir_lo_reg   <= gpm_pkg::RST_WORD;
			dir_hi_reg   <= gpm_pkg::RST_WORD;
			mask_reg     <= 1'b0;
			pin_in_reg   <= gpm_pkg::RST_PINS;
			pin_o_reg    <= gpm_pkg::RST_PINS;
			oe_n_reg     <= gpm_pkg::PINS_RELEASED;
			ss_reg       <= 1'b0;
		end else begin
			wr_state_reg <= wr_state_next;
			rd_state_reg <= rd_state_next;
			aw_got_reg   <= aw_got_next;
			w_got_reg    <= w_got_next;
			wr_idx_reg   <= wr_idx_next;
			wr_data_reg  <= wr_data_next;
			wr_strb_reg  <= wr_strb_next;
			bresp_reg    <= bresp_next;
			rdata_reg    <= rdata_next;
			rresp_reg    <= rresp_next;
			ctrl_reg     <= ctrl_next;
			out_lo_reg   <= out_lo_next;
			out_hi_reg   <= out_hi_next;
			dir_lo_reg   <= dir_lo_next;
			dir_hi_reg   <= dir_hi_next;
			mask_reg     <= mask_next;
			pin_in_reg   <= GPIO_I;
			pin_o_reg    <= pin_o_next;
			oe_n_reg     <= oe_n_next;
			ss_reg       <= ss_next;
		end
	end

	// Pin 24 is the external interrupt source
	assign irq_bus.level     = pin_in_reg[gpm_pkg::PIN_IRQ];
	assign irq_bus.rise_sel  = ctrl_reg[gpm_pkg::CTRL_POL_BIT];
	assign irq_bus.local_en  = ctrl_reg[gpm_pkg::CTRL_INTEN_BIT];
	assign irq_bus.global_en = PIN_INT_GLOBAL_EN_I;
	assign irq_bus.mask      = mask_reg;
	assign irq_bus.clr       = int_clr;

	gpm_edge_irq u_edge_irq (
		.clk_i   (CLK_SYS_I),
		.reset_i (RESET_I),
		.irq_bus (irq_bus)
	);

	// Peripheral inputs are taps of the registered pin sample
	always_comb begin
		for (int k = 0; k < HOST_W; k++) begin
			HOST_PORT_DIN_O[k] = pin_in_reg[host_pin(k)];
		end
	end

	assign FAST_SERIAL_DIN_O    = pin_in_reg[gpm_pkg::FSP_LSB+:4];
	assign SPI_DIN_O            = pin_in_reg[gpm_pkg::SPI_LSB+:4];
	assign SLAVE_SELECT_INPUT_O = ss_reg;
	assign GPIO_O               = pin_o_reg;
	assign GPIO_OE_N_O          = oe_n_reg;
	assign FAST_SERIAL_ROUTED_O = fsp_on;
	assign SPI_ROUTED_O         = spi_on;
	assign HOST_PORT_ROUTED_O   = host_on;
	// Scan code only reported; test logic is outside this block
	assign SCAN_MODE_O          = (mode == gpm_pkg::MODE_SCAN);
	assign IRQ_O                = irq_bus.irq;
	assign S_AXI_AWREADY_O      = (wr_state_reg == gpm_pkg::GPM_WR_IDLE) &
		~aw_got_reg;
	assign S_AXI_WREADY_O       = (wr_state_reg == gpm_pkg::GPM_WR_IDLE) &
		~w_got_reg;
	assign S_AXI_BVALID_O       = (wr_state_reg == gpm_pkg::GPM_WR_RESP);
	assign S_AXI_BRESP_O        = bresp_reg;
	assign S_AXI_ARREADY_O      = (rd_state_reg == gpm_pkg::GPM_RD_IDLE);
	assign S_AXI_RVALID_O       = (rd_state_reg == gpm_pkg::GPM_RD_DATA);
	assign S_AXI_RDATA_O        = rdata_reg;
	assign S_AXI_RRESP_O        = rresp_reg;
endmodule

`default_nettype wire

// file: testbench/gpm_port_chk.sv
`timescale 1ns/10ps
`default_nettype none

module gpm_port_chk #(
	parameter int HOST_W = 22
) (
	input wire logic              CLK_SYS_I,
	input wire logic              RESET_I,
	input wire logic              S_AXI_AWVALID_I,
	input wire logic              S_AXI_AWREADY_O,
	input wire logic              S_AXI_WVALID_I,
	input wire logic              S_AXI_WREADY_O,
	input wire logic              S_AXI_BVALID_O,
	input wire logic              S_AXI_BREADY_I,
	input wire logic              S_AXI_ARVALID_I,
	input wire logic              S_AXI_ARREADY_O,
	input wire logic              S_AXI_RVALID_O,
	input wire logic              S_AXI_RREADY_I,
	input wire logic [31:0]       GPIO_O,
	input wire logic [31:0]       GPIO_OE_N_O,
	input wire logic [3:0]        FAST_SERIAL_DOUT_I,
	input wire logic [3:0]        FAST_SERIAL_DRIVE_I,
	input wire logic [3:0]        SPI_DOUT_I,
	input wire logic [3:0]        SPI_DRIVE_I,
	input wire logic [HOST_W-1:0] HOST_PORT_DOUT_I,
	input wire logic [HOST_W-1:0] HOST_PORT_DRIVE_I,
	input wire logic              PIN_INT_GLOBAL_EN_I,
	input wire logic              FAST_SERIAL_ROUTED_O,
	input wire logic              SPI_ROUTED_O,
	input wire logic              HOST_PORT_ROUTED_O,
	input wire logic              IRQ_O
);
	// One clock domain, so one clocking and one disable for all
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);

	// First edge after reset must still show every pin released
	chk_reset_state: assert property (
		$past(RESET_I) |-> GPIO_OE_N_O == 32'hffff_ffff && !IRQ_O)
		else $error("pins or irq not idle after reset");
	chk_unused_pins: assert property (
		&GPIO_OE_N_O[28:25])
		else $error("unlisted high pin driven");
	// Pin 15 left out: the alternate select may claim it
	chk_fast_serial: assert property (
		FAST_SERIAL_ROUTED_O && !HOST_PORT_ROUTED_O |=>
		GPIO_O[14:12] == $past(FAST_SERIAL_DOUT_I[2:0]) &&
		GPIO_OE_N_O[14:12] == ~$past(FAST_SERIAL_DRIVE_I[2:0]))
		else $error("fast serial not on pins");
	// Pin 9 left out: it returns to plain use under the alternate route
	chk_spi_pins: assert property (
		SPI_ROUTED_O && !HOST_PORT_ROUTED_O |=>
		GPIO_O[11:10] == $past(SPI_DOUT_I[3:2]) &&
		GPIO_OE_N_O[11:10] == ~$past(SPI_DRIVE_I[3:2]))
		else $error("spi not on pins");
	chk_host_slots: assert property (
		HOST_PORT_ROUTED_O |=>
		GPIO_O[15:0] == $past(HOST_PORT_DOUT_I[15:0]) &&
		GPIO_OE_N_O[15:0] == ~$past(HOST_PORT_DRIVE_I[15:0]))
		else $error("host port not on pins");
	chk_irq_gated: assert property (
		IRQ_O |-> $past(PIN_INT_GLOBAL_EN_I))
		else $error("irq without global enable");
	// Bus answers within the figures of the hand-over
	chk_write_answer: assert property (
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I &&
		S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O)
		else $error("write answer late");
	chk_read_answer: assert property (
		S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
		else $error("read answer late");
	chk_read_release: assert property (
		S_AXI_RVALID_O && S_AXI_RREADY_I |=>
		!S_AXI_RVALID_O && S_AXI_ARREADY_O)
		else $error("read channel not released");

	cov_host: cover property (HOST_PORT_ROUTED_O);
	cov_spi: cover property (SPI_ROUTED_O && FAST_SERIAL_ROUTED_O);
	cov_irq: cover property ($rose(IRQ_O));
endmodule

bind gpm_port gpm_port_chk #(.HOST_W(HOST_W)) u_chk (
	.CLK_SYS_I, .RESET_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
	.S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
	.S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I,
	.GPIO_O, .GPIO_OE_N_O, .FAST_SERIAL_DOUT_I, .FAST_SERIAL_DRIVE_I,
	.SPI_DOUT_I, .SPI_DRIVE_I, .HOST_PORT_DOUT_I, .HOST_PORT_DRIVE_I,
	.PIN_INT_GLOBAL_EN_I, .FAST_SERIAL_ROUTED_O, .SPI_ROUTED_O,
	.HOST_PORT_ROUTED_O, .IRQ_O
);

`default_nettype wire

// file: testbench/gpm_pins_model.sv
`timescale 1ns/10ps
`default_nettype none

module gpm_pins_model (
	input  wire logic        clk_i,
	input  wire logic [31:0] pin_out_i,
	input  wire logic [31:0] pin_oe_n_i,
	input  wire logic [31:0] ext_lvl_i,
	input  wire logic [31:0] ext_en_i,
	output logic [31:0]      pin_lvl_o
);
	logic [31:0] last_reg;

	// Device wins where it drives; an undriven pin has no pull, so it
	// flips every cycle rather than hold a value by luck
	always_comb begin
		pin_lvl_o = (~pin_oe_n_i & pin_out_i) |
			(pin_oe_n_i & ext_en_i & ext_lvl_i) |
			(pin_oe_n_i & ~ext_en_i & ~last_reg);
	end

	always_ff @(posedge clk_i) begin
		last_reg <= pin_lvl_o;
	end
endmodule

`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
	$display("Error %0t got %h exp %h", $time, (a), (b)); end end

module tb_top;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [17:0] awaddr = '0, araddr = '0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0, tx_st = 1'h0, gen = 1'h0;
	logic [31:0] wdata = '0, ext_lvl = '0, ext_en = '1;
	logic [3:0]  fs_dout = '0, fs_drv = '0, spi_dout = '0, spi_drv = '0;
	logic [3:0]  sdin;
	logic [21:0] hp_dout = '0, hp_drv = '0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic        fs_rt, spi_rt, hp_rt, ss;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, pins, gpo, oe_n;
	int          n_fail = 0, checks = 0;
	logic [15:0] ridx [9] = '{gpm_pkg::IDX_CTRL, gpm_pkg::IDX_OUT_LO,
		gpm_pkg::IDX_IN_LO, gpm_pkg::IDX_DIR_LO, gpm_pkg::IDX_OUT_HI,
		gpm_pkg::IDX_IN_HI, gpm_pkg::IDX_DIR_HI, gpm_pkg::IDX_INT_STAT,
		gpm_pkg::IDX_INT_MASK};

	always #5 clk = ~clk;

	gpm_port dut (
		.CLK_SYS_I(clk), .RESET_I(rst), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'h3),
		.S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
		.S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
		.S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
		.GPIO_I(pins), .GPIO_O(gpo), .GPIO_OE_N_O(oe_n),
		.FAST_SERIAL_DOUT_I(fs_dout), .FAST_SERIAL_DRIVE_I(fs_drv),
		.FAST_SERIAL_DIN_O(), .SPI_DOUT_I(spi_dout),
		.SPI_DRIVE_I(spi_drv), .SPI_DIN_O(sdin), .SLAVE_SELECT_INPUT_O(ss),
		.HOST_PORT_DOUT_I(hp_dout), .HOST_PORT_DRIVE_I(hp_drv),
		.HOST_PORT_DIN_O(), .TX_ENABLE_STATE_I(tx_st),
		.PIN_INT_GLOBAL_EN_I(gen), .FAST_SERIAL_ROUTED_O(fs_rt),
		.SPI_ROUTED_O(spi_rt), .HOST_PORT_ROUTED_O(hp_rt),
		.SCAN_MODE_O(), .IRQ_O(irq)
	);

	gpm_pins_model u_pins (
		.clk_i(clk), .pin_out_i(gpo), .pin_oe_n_i(oe_n),
		.ext_lvl_i(ext_lvl), .ext_en_i(ext_en), .pin_lvl_o(pins)
	);

	task automatic wrap_up();
		if (n_fail == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic do_reset();
		rst <= 1'h1;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
	endtask

	// Let writes reach the pins and pin levels reach the samplers
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [15:0] idx, input logic [15:0] d);
		@(posedge clk);
		awaddr <= {idx, 2'h0};
		wdata <= {16'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		`CHK(bresp, gpm_pkg::RESP_OKAY)
	endtask

	task automatic rchk(input logic [15:0] idx, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge clk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
		`CHK(rdata, e)
		`CHK(rresp, er)
	endtask

	task automatic pin24(input logic v);
		@(posedge clk);
		ext_lvl[24] <= v;
		repeat (4) @(posedge clk);
		#1;
	endtask

	// Every register reads zero and every pin is released
	task automatic t_reset();
		settle();
		`CHK(oe_n, gpm_pkg::PINS_RELEASED)
		`CHK(gpo, gpm_pkg::RST_PINS)
		for (int i = 0; i < 9; i++) begin
			rchk(ridx[i], 32'h0, gpm_pkg::RESP_OKAY);
		end
	endtask

	task automatic t_lo();
		wr(gpm_pkg::IDX_OUT_LO, 16'ha5c3);
		wr(gpm_pkg::IDX_DIR_LO, 16'h00ff);
		ext_lvl[15:0] <= 16'h3c00;
		settle();
		`CHK(gpo[7:0], 8'hc3)
		`CHK(oe_n[15:0], 16'hff00)
		rchk(gpm_pkg::IDX_OUT_LO, 32'ha5c3, gpm_pkg::RESP_OKAY);
		rchk(gpm_pkg::IDX_IN_LO, 32'h3cc3, gpm_pkg::RESP_OKAY);
		wr(gpm_pkg::IDX_IN_LO, 16'hffff);
		rchk(gpm_pkg::IDX_IN_LO, 32'h3cc3, gpm_pkg::RESP_OKAY);
		rchk(16'hc040, 32'h0, gpm_pkg::RESP_SLVERR);
	endtask

	task automatic t_hi();
		wr(gpm_pkg::IDX_OUT_HI, 16'he1f8);
		wr(gpm_pkg::IDX_DIR_HI, 16'he1f8);
		settle();
		`CHK(oe_n, 32'h1e07_ff00)
		rchk(gpm_pkg::IDX_OUT_HI, 32'he1f8, gpm_pkg::RESP_OKAY);
		rchk(gpm_pkg::IDX_IN_HI, 32'he1f8, gpm_pkg::RESP_OKAY);
		wr(gpm_pkg::IDX_DIR_HI, 16'h0);
		wr(gpm_pkg::IDX_OUT_HI, 16'h0);
		wr(gpm_pkg::IDX_CTRL, 16'h4000);
		tx_st <= 1'h1;
		settle();
		`CHK(gpo[30], 1'h1)
		`CHK(oe_n[30], 1'h0)
		wr(gpm_pkg::IDX_CTRL, 16'h0);
	endtask

	// Pin 15 stays undriven so the two select sources differ
	task automatic t_route();
		hp_drv <= '1;
		hp_dout <= 22'h2aaaaa;
		fs_drv <= 4'h7;
		fs_dout <= 4'ha;
		spi_drv <= 4'h5;
		spi_dout <= 4'h1;
		ext_lvl[9] <= 1'h1;
		wr(gpm_pkg::IDX_CTRL, 16'h00a0);
		settle();
		`CHK(oe_n[15:8], 8'h8a)
		`CHK(gpo[14:12], 3'h2)
		`CHK(gpo[8], 1'h1)
		`CHK(ss, 1'h1)
		`CHK({fs_rt, spi_rt}, 2'h3)
		`CHK(sdin, 4'hb)
		wr(gpm_pkg::IDX_CTRL, 16'h08a0);
		settle();
		`CHK(ss, 1'h0)
		wr(gpm_pkg::IDX_CTRL, 16'h0);
		settle();
		`CHK(oe_n[15:8], 8'hff)
		for (int c = 0; c < 8; c++) begin
			if (c == 6) continue;
			wr(gpm_pkg::IDX_CTRL, {5'h0, c[2:0], 8'h0});
			settle();
			`CHK(hp_rt, c == 5)
		end
		wr(gpm_pkg::IDX_CTRL, 16'h0500);
		settle();
		`CHK(gpo[24:19], 6'h2a)
		`CHK(oe_n[24:19], 6'h0)
		`CHK(gpo[15:0], 16'haaaa)
		wr(gpm_pkg::IDX_CTRL, 16'h0);
	endtask

	task automatic t_irq();
		gen <= 1'h1;
		wr(gpm_pkg::IDX_INT_MASK, 16'h1);
		wr(gpm_pkg::IDX_CTRL, 16'h0003);
		wr(gpm_pkg::IDX_INT_STAT, 16'h1);
		pin24(1'h1);
		`CHK(irq, 1'h1)
		rchk(gpm_pkg::IDX_INT_STAT, 32'h1, gpm_pkg::RESP_OKAY);
		wr(gpm_pkg::IDX_INT_STAT, 16'h1);
		pin24(1'h0);
		`CHK(irq, 1'h0)
		wr(gpm_pkg::IDX_CTRL, 16'h0001);
		pin24(1'h1);
		`CHK(irq, 1'h0)
		pin24(1'h0);
		`CHK(irq, 1'h1)
		wr(gpm_pkg::IDX_INT_STAT, 16'h1);
		gen <= 1'h0;
		pin24(1'h1);
		pin24(1'h0);
		`CHK(irq, 1'h0)
		wr(gpm_pkg::IDX_INT_STAT, 16'h1);
		gen <= 1'h1;
		wr(gpm_pkg::IDX_CTRL, 16'h0);
		pin24(1'h1);
		pin24(1'h0);
		`CHK(irq, 1'h0)
	endtask

	// Locked field survives writes until a reset in mid-run frees it
	task automatic t_lock();
		wr(gpm_pkg::IDX_CTRL, 16'h8500);
		wr(gpm_pkg::IDX_CTRL, 16'h00a0);
		rchk(gpm_pkg::IDX_CTRL, 32'h85a0, gpm_pkg::RESP_OKAY);
		ext_lvl <= '0;
		do_reset();
		t_reset();
	endtask

	initial begin
		do_reset();
		t_reset();
		t_lo();
		t_hi();
		t_route();
		t_irq();
		t_lock();
		wrap_up();
	end

	// Watchdog well past the few hundred cycles the run needs
	initial begin
		#200us;
		n_fail++;
		wrap_up();
	end
endmodule

`default_nettype wire
